// >>> verilog/zcd_pkg.sv
// package: constants for the crossing detector logic
// ----------------------------------------------------------------------------
// How it works
// [R01] analog sink level enters as raw input
// [R02] logic out equals sink level normally
// [R03] invert control flips the logic output
// [R04] inversion applies even while detector disabled
// [R05] edges detected after polarity inversion
// [R06] separate rise and fall detectors, each enabled
// [R07] qualified edge sets sticky crossing flag
// [R08] request needs flag and three enables
// [R09] invert write may create edge, set flag
// [R10] software clears flag; hardware never does
// [R11] set wins over simultaneous clear
// [R12] software disables pin pull-up before use
// [R13] control bits 7,5,4,1,0; rest zero
// [R14] enabled detector owns pin, else normal
// [R15] enable resets per default-off strap
// [R16] logic keeps running during sleep
// [R17] two-stage synchronizer on raw level
// [R18] edge pulse from current vs previous
// ----------------------------------------------------------------------------
package zcd_pkg;
  localparam logic [11:0] ZCD_CTRL_OFS = 12'h000;
  localparam logic [11:0] ZCD_STAT_OFS = 12'h004;
  localparam logic [11:0] ZCD_MASK_OFS = 12'h008;
  localparam logic [11:0] ZCD_GATE_OFS = 12'h00C;
  localparam int ZCD_EN_BIT = 7;
  localparam int ZCD_OUT_BIT = 5;
  localparam int ZCD_INV_BIT = 4;
  localparam int ZCD_RISE_BIT = 1;
  localparam int ZCD_FALL_BIT = 0;
  localparam int ZCD_GLOBAL_BIT = 1;
  localparam int ZCD_PERIPH_BIT = 0;
  localparam logic [7:0] ZCD_CTRL_WMASK = 8'h93;
  localparam logic [7:0] ZCD_CTRL_RST = 8'h00;
  localparam logic [1:0] ZCD_GATE_RST = 2'h0;
  localparam int ZCD_SYNC_STAGES = 2;
endpackage

// >>> verilog/zcd_sync.sv
// two-flop level synchronizer
`timescale 1ns/1ps
`default_nettype none
module zcd_sync #(
  parameter int STAGES = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  logic [STAGES-1:0] sr_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sr_q <= '0;
    end
    else
    begin
      sr_q <= {sr_q[STAGES-2:0], d}; // [R17]
    end
  end
  assign q = sr_q[STAGES-1];
endmodule // zcd_sync
`default_nettype wire

// >>> verilog/zcd_edge.sv
// edge detector on the polarity-adjusted output
`timescale 1ns/1ps
`default_nettype none
module zcd_edge (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic level,
  output logic rise,
  output logic fall
);
  logic prev_q;
  logic seen_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_q <= 1'b0;
      seen_q <= 1'b0;
    end
    else
    begin
      prev_q <= level;
      seen_q <= 1'b1;
    end
  end
  // no edge reported on the first sample after reset
  assign rise = seen_q & level & ~prev_q; // [R18]
  assign fall = seen_q & ~level & prev_q; // [R18]
endmodule // zcd_edge
`default_nettype wire

// >>> verilog/zcd_logic.sv
// crossing detector digital logic with apb registers
`timescale 1ns/1ps
`default_nettype none
module zcd_logic (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sink_active_raw,
  input wire logic detector_default_off,
  output logic detector_active,
  output logic crossing_logic_out,
  output logic irq
);
  import zcd_pkg::*;

  // --------------------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------------------
  wire access_w = psel & penable;
  wire wr_w = access_w & pwrite & pstrb[0];
  wire sel_ctrl = paddr == ZCD_CTRL_OFS;
  wire sel_stat = paddr == ZCD_STAT_OFS;
  wire sel_mask = paddr == ZCD_MASK_OFS;
  wire sel_gate = paddr == ZCD_GATE_OFS;
  wire mapped_w = sel_ctrl | sel_stat | sel_mask | sel_gate;
  wire wr_ctrl = wr_w & sel_ctrl;
  wire wr_stat = wr_w & sel_stat;
  wire wr_mask = wr_w & sel_mask;
  wire wr_gate = wr_w & sel_gate;

  // --------------------------------------------------------------------------
  // control state
  // --------------------------------------------------------------------------
  logic [7:0] ctrl_q;
  logic [1:0] gate_q;
  logic crossing_irq_enable_q;
  logic crossing_irq_flag_q;
  logic strap_done_q;
  logic [31:0] prdata_q;
  logic out_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q <= ZCD_CTRL_RST;
      strap_done_q <= 1'b0;
    end
    else if (!strap_done_q)
    begin
      // strap caught on first edge after release
      strap_done_q <= 1'b1;
      ctrl_q[ZCD_EN_BIT] <= ~detector_default_off; // [R15]
    end
    else if (wr_ctrl)
    begin
      ctrl_q <= pwdata[7:0] & ZCD_CTRL_WMASK; // [R13]
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gate_q <= ZCD_GATE_RST;
      crossing_irq_enable_q <= 1'b0;
    end
    else
    begin
      if (wr_gate)
      begin
        gate_q <= pwdata[1:0];
      end
      if (wr_mask)
      begin
        crossing_irq_enable_q <= pwdata[0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // detector path
  // --------------------------------------------------------------------------
  logic sink_sync;
  logic rise_pulse;
  logic fall_pulse;

  // raw level is the analog sink state
  zcd_sync #(.STAGES(ZCD_SYNC_STAGES)) u_sync ( // [R01]
    .clk(clk),
    .rst_n(rst_n),
    .d(sink_active_raw),
    .q(sink_sync)
  );

  // polarity applies regardless of enable; also runs in sleep
  wire invert_w = ctrl_q[ZCD_INV_BIT];
  wire out_w = sink_sync ^ invert_w; // [R02] [R03] [R04] [R16]

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_q <= 1'b0;
    end
    else
    begin
      out_q <= out_w;
    end
  end

  // a write to the invert bit flips out_w and yields an edge
  zcd_edge u_edge ( // [R05] [R09]
    .clk(clk),
    .rst_n(rst_n),
    .level(out_w),
    .rise(rise_pulse),
    .fall(fall_pulse)
  );

  wire rise_hit = rise_pulse & ctrl_q[ZCD_RISE_BIT]; // [R06]
  wire fall_hit = fall_pulse & ctrl_q[ZCD_FALL_BIT]; // [R06]
  wire set_flag = rise_hit | fall_hit; // [R07]
  wire clr_flag = wr_stat & pwdata[0];

  // --------------------------------------------------------------------------
  // sticky flag
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      crossing_irq_flag_q <= 1'b0;
    end
    else if (set_flag)
    begin
      crossing_irq_flag_q <= 1'b1; // [R07] [R11]
    end
    else if (clr_flag)
    begin
      crossing_irq_flag_q <= 1'b0; // [R10]
    end
  end

  // --------------------------------------------------------------------------
  // read data
  // --------------------------------------------------------------------------
  wire [7:0] ctrl_rd = {ctrl_q[7:6], out_q, ctrl_q[4:0]}; // [R13]
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h00000000;
    if (sel_ctrl)
    begin
      rd_mux = {24'h000000, ctrl_rd};
    end
    else if (sel_stat)
    begin
      rd_mux = {31'h00000000, crossing_irq_flag_q};
    end
    else if (sel_mask)
    begin
      rd_mux = {31'h00000000, crossing_irq_enable_q};
    end
    else if (sel_gate)
    begin
      rd_mux = {30'h00000000, gate_q};
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata_q <= 32'h00000000;
    end
    else if (psel & ~penable & ~pwrite)
    begin
      prdata_q <= rd_mux;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = access_w & ~mapped_w;
  assign crossing_logic_out = out_q;
  assign detector_active = ctrl_q[ZCD_EN_BIT]; // [R14]
  assign irq = crossing_irq_flag_q & crossing_irq_enable_q // [R08]
             & gate_q[ZCD_PERIPH_BIT] & gate_q[ZCD_GLOBAL_BIT];

endmodule // zcd_logic
`default_nettype wire

// >>> testbench/zcd_src.sv
// far side: ac source through series resistor
`timescale 1ns/1ps
`default_nettype none
module zcd_src (
  input wire logic above,
  output logic sink
);
  // pin has no pull-up, only sink or source sets it
  always @(above)
    sink <= #3 above;
  initial
    sink = 1'b0;
endmodule // zcd_src
`default_nettype wire

// >>> testbench/zcd_chk.sv
// port assertions for the crossing detector logic
`timescale 1ns/1ps
`default_nettype none
module zcd_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic sink_active_raw,
  input wire logic detector_default_off,
  input wire logic detector_active,
  input wire logic crossing_logic_out,
  input wire logic irq
);
  import zcd_pkg::*;
  logic [7:0] c_q;
  logic m_q;
  logic [1:0] g_q;
  logic [2:0] age_q;
  wire wr = psel & penable & pwrite & pstrb[0];
  wire clr = wr && paddr == ZCD_STAT_OFS && pwdata[0];
  wire on = m_q && (&g_q);
  wire lo = crossing_logic_out;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      c_q <= 8'h00;
      m_q <= 1'b0;
      g_q <= 2'h0;
      age_q <= 3'h0;
    end
    else
    begin
      if (wr && paddr == ZCD_CTRL_OFS)
        c_q <= pwdata[7:0];
      if (wr && paddr == ZCD_MASK_OFS)
        m_q <= pwdata[0];
      if (wr && paddr == ZCD_GATE_OFS)
        g_q <= pwdata[1:0];
      if (age_q != 3'h7)
        age_q <= age_q + 3'h1;
    end
  end
  a_out_follow: assert property (age_q > 3'h3 |->
    lo == ($past(sink_active_raw, 3) ^ $past(c_q[4]))) else $error("logic out wrong");
  a_rise_sets: assert property ($rose(lo) && $past(c_q[1]) && on |-> irq)
    else $error("rise missed");
  a_fall_sets: assert property ($fell(lo) && $past(c_q[0]) && on |-> irq)
    else $error("fall missed");
  a_irq_cause: assert property ($rose(irq) && $stable(on) |->
    ($rose(lo) && $past(c_q[1])) || ($fell(lo) && $past(c_q[0]))) else $error("bad set");
  a_flag_sticky: assert property ($fell(irq) && $stable(on) |-> $past(clr))
    else $error("flag lost");
  a_irq_gate: assert property (irq |-> on) else $error("irq ungated");
  a_unmapped_err: assert property (psel && penable && paddr > ZCD_GATE_OFS |-> pslverr)
    else $error("no slverr");
  a_ctrl_zero: assert property (psel && penable && !pwrite && paddr == 12'h000 |->
    (prdata & 32'hFFFFFF4C) == 32'h0) else $error("unused bits set");
  a_active_en: assert property ($past(wr && paddr == 12'h000) |->
    detector_active == $past(pwdata[7])) else $error("active wrong");
  a_en_reset: assert property (age_q == 3'h1 |->
    detector_active == !$past(detector_default_off)) else $error("enable reset wrong");
endmodule // zcd_chk
bind zcd_logic zcd_chk i_zcd_chk (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pslverr(pslverr), .sink_active_raw(sink_active_raw), .irq(irq),
  .detector_default_off(detector_default_off), .detector_active(detector_active),
  .crossing_logic_out(crossing_logic_out));
`default_nettype wire

// >>> testbench/testbench.sv
// register-level test of the crossing detector logic
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import zcd_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic above = 1'b0;
  logic strap = 1'b1;
  logic sink;
  logic active;
  logic lout;
  logic irq;
  logic [31:0] rd;
  logic err;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  zcd_logic i_zcd_logic (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sink_active_raw(sink), .irq(irq),
    .detector_default_off(strap), .detector_active(active), .crossing_logic_out(lout));
  zcd_src i_zcd_src (.above(above), .sink(sink));
  initial
  begin
    forever #5 clk = ~clk;
  end
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_errors++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rdc(ZCD_CTRL_OFS, 32'h0);
    wr(ZCD_GATE_OFS, 32'h3);
    wr(ZCD_MASK_OFS, 32'h1);
    rdc(ZCD_GATE_OFS, 32'h3);
    wr(ZCD_CTRL_OFS, 32'h13);
    settle();
    chk(irq, 1'b1);
    chk(active, 1'b0);
    rdc(ZCD_CTRL_OFS, 32'h33);
    rdc(ZCD_STAT_OFS, 32'h1);
    wr(ZCD_STAT_OFS, 32'h1);
    chk(irq, 1'b0);
    wr(ZCD_CTRL_OFS, 32'h90);
    chk(active, 1'b1);
    above <= 1'b1;
    settle();
    rdc(ZCD_CTRL_OFS, 32'h90);
    chk(irq, 1'b0);
    wr(ZCD_CTRL_OFS, 32'h01);
    settle();
    chk(irq, 1'b0);
    rdc(ZCD_CTRL_OFS, 32'h21);
    above <= 1'b0;
    settle();
    chk(irq, 1'b1);
    wr(ZCD_MASK_OFS, 32'h0);
    chk(irq, 1'b0);
    wr(ZCD_MASK_OFS, 32'h1);
    wr(ZCD_GATE_OFS, 32'h1);
    chk(irq, 1'b0);
    wr(ZCD_GATE_OFS, 32'h2);
    chk(irq, 1'b0);
    wr(ZCD_GATE_OFS, 32'h3);
    chk(irq, 1'b1);
    wr(ZCD_CTRL_OFS, 32'h02);
    above <= 1'b1;
    wr(ZCD_STAT_OFS, 32'h1);
    #20;
    chk(irq, 1'b1);
    pstrb <= 4'hE;
    wr(ZCD_STAT_OFS, 32'h1);
    pstrb <= 4'hF;
    chk(irq, 1'b1);
    wr(ZCD_STAT_OFS, 32'h1);
    chk(irq, 1'b0);
    xfer(1'b1, 12'h010, 32'hFF);
    chk(err, 1'b1);
    rdc(12'h010, 32'h0);
    chk(err, 1'b1);
    above <= 1'b0;
    settle();
    strap <= 1'b0;
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rdc(ZCD_CTRL_OFS, 32'h80);
    chk(active, 1'b1);
    rdc(ZCD_MASK_OFS, 32'h0);
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
